// ===== ris_pkg.sv
/*
 Package for the reader interrupt status and collision position block.
 Assumes a device-internal register port with byte-wide data and 5-bit addresses.
*/
package ris_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [4:0] ADDR_PROTO_CTRL = 5'h01;
   localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0c;
   localparam logic [4:0] ADDR_COL_MASK   = 5'h0d;
   localparam logic [4:0] ADDR_COL_LOW    = 5'h0e;
   localparam logic [7:0] STATUS_RESET    = 8'h00;
   localparam logic [5:0] MASK_RESET      = 6'h3e;
   localparam logic [9:0] COL_RESET       = 10'h000;

   // ------------------------------------------------------------
   // Status bit positions
   // ------------------------------------------------------------
   localparam int BIT_TX     = 7;
   localparam int BIT_RX     = 6;
   localparam int BIT_FIFO   = 5;
   localparam int BIT_CRC    = 4;
   localparam int BIT_PARITY = 3;
   localparam int BIT_FRAME  = 2;
   localparam int BIT_COL    = 1;
   localparam int BIT_NORESP = 0;
   localparam int PROTO_NOCRC_BIT = 7;

   // FIFO level thresholds
   localparam logic [4:0] FIFO_HIGH_LVL = 5'h08;
   localparam logic [4:0] FIFO_LOW_LVL  = 5'h04;

   // Collision hits per bit period, selected by colThreshSel
   localparam logic [2:0] COL_THRESH_HI = 3'h7;
   localparam logic [2:0] COL_THRESH_LO = 3'h6;

   // Front-end events, one-cycle pulses unless noted
   typedef struct packed {
      logic       txStart;
      logic       txDone;
      logic       rxSof;
      logic       rxDone;
      logic       crcErr;
      logic       parityErr;
      logic       frameErr;
      logic       colEvent;
      logic       noResp;
      logic [9:0] errBitPos;
   } ris_evt_t;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_TX   = 2'b01,
      PH_RX   = 2'b11
   } ris_phase_t;
endpackage

// ===== ris_irq_status.sv
/*
 Interrupt status, mask and collision position logic of the reader.
 Holds the status, the per-event enables and the ten-bit collision
 position, and drives the single interrupt line toward the host.
 Assumes events come from same-clock logic; enable pin arrives asynchronously.
 Assumes the host port decodes strobes to one-cycle pulses.
*/
`timescale 1ns/10ps
// Overview of operation
// - Status clears on reset, control write, read end
// - Transmit flag sets at start, irq at end
// - Receive flag sets at SOF, irq at end
// - FIFO flag: below 4 tx only; rx level never flags
// - CRC error only when CRC check enabled
// - Parity error bit 3, framing error bit 2
// - Collision at or above selectable 6 or 7 threshold
// - No-response timeout sets bit 0
// - Host read of status clears it, drops irq
// - During transmit only bits 5, 7 change
// - During receive only bit 6 changes
// - Mask resets to 0x3e, per-event enables
// - Ten-bit collision position over two registers
// - Collision position clears on reset or read
// - Other protocols record error bit position
module ris_irq_status (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   // Enable pin, asynchronous
   input  wire logic             enablePin,
   // Register port
   input  wire logic [4:0]       regAddr,
   input  wire logic [7:0]       regWdata,
   input  wire logic             regWr,
   input  wire logic             regRd,
   input  wire logic             readEnd,
   output logic      [7:0]       regRdata,
   // Front-end events and levels
   input  wire ris_pkg::ris_evt_t evt,
   input  wire logic [4:0]       fifoCount,
   input  wire logic             typeAMode,
   input  wire logic             colThreshSel,
   input  wire logic [2:0]       colCount,
   // Outputs
   output logic                  decoderEn,
   output logic                  irqOut
);

   // ------------------------------------------------------------
   // Enable pin synchroniser
   // ------------------------------------------------------------
   logic enMeta_ff;
   logic enSync_ff;
   // Two stages; only enSync_ff feeds logic
   // The pin is asynchronous to mclk, so the first stage may go
   // metastable; nothing but the second stage ever reads it.
   // Cost: enable low takes effect two edges late.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         enMeta_ff <= 1'b0;
         enSync_ff <= 1'b0;
      end else begin
         enMeta_ff <= enablePin;
         enSync_ff <= enMeta_ff;
      end
   end

   logic softClr;
   // Enable low acts like a soft reset of every register below except regRdata
   // Kept synchronous so its release never races the clock edge
   assign softClr = !enSync_ff;

   // ------------------------------------------------------------
   // Phase tracking
   // ------------------------------------------------------------
   ris_pkg::ris_phase_t phase_ff;
   ris_pkg::ris_phase_t nxt_phase;
   logic                txPhase;
   logic                rxPhase;
   assign txPhase = (phase_ff == ris_pkg::PH_TX);
   assign rxPhase = (phase_ff == ris_pkg::PH_RX);

   // Next phase from frame events
   // A start seen mid-phase is ignored; the front end must
   // close one frame before opening the next.
   always_comb begin
      nxt_phase = phase_ff;
      case (phase_ff)
         ris_pkg::PH_IDLE: begin
            if (evt.txStart) begin
               nxt_phase = ris_pkg::PH_TX;
            end else if (evt.rxSof) begin
               nxt_phase = ris_pkg::PH_RX;
            end
         end
         ris_pkg::PH_TX: begin
            if (evt.txDone) begin
               nxt_phase = ris_pkg::PH_IDLE;
            end
         end
         ris_pkg::PH_RX: begin
            if (evt.rxDone) begin
               nxt_phase = ris_pkg::PH_IDLE;
            end
         end
         default: nxt_phase = ris_pkg::PH_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase_ff <= ris_pkg::PH_IDLE;
      end else if (softClr) begin
         phase_ff <= ris_pkg::PH_IDLE;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // Decoder gated off while transmitting
   // Combinational so it drops in the first transmit cycle
   assign decoderEn = !txPhase;

   // ------------------------------------------------------------
   // Protocol control shadow (receive CRC disable)
   // ------------------------------------------------------------
   logic noRxCrc_ff;
   logic protoWr;
   assign protoWr = regWr && (regAddr == ris_pkg::ADDR_PROTO_CTRL);
   // Only the no-CRC bit is kept; the rest of that register
   // lives elsewhere in the device.

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         noRxCrc_ff <= 1'b0;
      end else if (softClr) begin
         noRxCrc_ff <= 1'b0;
      end else if (protoWr) begin
         noRxCrc_ff <= regWdata[ris_pkg::PROTO_NOCRC_BIT];
      end
   end

   // ------------------------------------------------------------
   // Event qualification
   // ------------------------------------------------------------
   logic [7:0] setVec;
   logic       colHit;
   logic       fifoHit;
   logic       anyErr;

   // Threshold 6 or 7 hits per bit period; sel high picks 7
   // Reaching the threshold counts as a hit; noise alone can
   // trip it, which is why the host may mask it.
   assign colHit = typeAMode && evt.colEvent &&
                   (colCount > ((colThreshSel ? ris_pkg::COL_THRESH_HI
                                              : ris_pkg::COL_THRESH_LO) - 3'h1));
   assign fifoHit = (rxPhase && (fifoCount > ris_pkg::FIFO_HIGH_LVL)) ||
                    (txPhase && (fifoCount < ris_pkg::FIFO_LOW_LVL));

   // Decoder errors are blocked in tx and rx so only 5/7 or 6 move
   // Trade-off: a FIFO level reached during receive is not
   // flagged, since only the receive bit may move then.
   always_comb begin
      setVec = 8'h00;
      setVec[ris_pkg::BIT_TX]   = evt.txStart && !rxPhase;
      setVec[ris_pkg::BIT_RX]   = evt.rxSof && !txPhase;
      setVec[ris_pkg::BIT_FIFO] = fifoHit && !rxPhase;
      if (!txPhase && !rxPhase) begin
         setVec[ris_pkg::BIT_CRC]    = evt.crcErr && !noRxCrc_ff;
         setVec[ris_pkg::BIT_PARITY] = evt.parityErr && typeAMode;
         setVec[ris_pkg::BIT_FRAME]  = evt.frameErr;
         setVec[ris_pkg::BIT_COL]    = colHit;
         setVec[ris_pkg::BIT_NORESP] = evt.noResp;
      end
   end

   assign anyErr = |setVec[ris_pkg::BIT_CRC:ris_pkg::BIT_COL];

   // ------------------------------------------------------------
   // Interrupt status register
   // ------------------------------------------------------------
   logic [7:0] status_ff;
   logic       statusRd;
   logic       statusClr;
   assign statusRd  = regRd && (regAddr == ris_pkg::ADDR_IRQ_STATUS);
   assign statusClr = protoWr || readEnd || statusRd;

   // Each bit sticky; a set in the clearing cycle survives
   // so an event that races the host read is never lost; the
   // line then returns a cycle after the clear.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : gStatus
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               status_ff[gi] <= ris_pkg::STATUS_RESET[gi];
            end else if (softClr) begin
               status_ff[gi] <= ris_pkg::STATUS_RESET[gi];
            end else if (setVec[gi]) begin
               status_ff[gi] <= 1'b1;
            end else if (statusClr) begin
               status_ff[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Mask and collision position
   // ------------------------------------------------------------
   logic [5:0] mask_ff;
   logic [9:0] colPos_ff;
   logic       maskWr;
   logic       colHiRd;
   logic       colLoRd;
   assign maskWr  = regWr && (regAddr == ris_pkg::ADDR_COL_MASK);
   assign colHiRd = regRd && (regAddr == ris_pkg::ADDR_COL_MASK);
   assign colLoRd = regRd && (regAddr == ris_pkg::ADDR_COL_LOW);

   // Mask bits: fifo, crc, parity, framing, collision, no-response
   // Bits 7:6 at that address are the collision top bits, read only
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask_ff <= ris_pkg::MASK_RESET;
      end else if (softClr) begin
         mask_ff <= ris_pkg::MASK_RESET;
      end else if (maskWr) begin
         mask_ff <= regWdata[5:0];
      end
   end

   // Collision position; new capture wins over read clear
   // Each half clears only on a read of its own register, so a
   // host that reads just the low byte keeps the top bits.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         colPos_ff <= ris_pkg::COL_RESET;
      end else if (softClr) begin
         colPos_ff <= ris_pkg::COL_RESET;
      end else if (colHit || (!typeAMode && anyErr)) begin
         colPos_ff <= evt.errBitPos;
      end else begin
         if (colHiRd) begin
            colPos_ff[9:8] <= ris_pkg::COL_RESET[9:8];
         end
         if (colLoRd) begin
            colPos_ff[7:0] <= ris_pkg::COL_RESET[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Interrupt line
   // ------------------------------------------------------------
   // Tx/rx flags raise the line whenever their own phase is not running
   logic phaseEndIrq;
   logic irq_ff;
   assign phaseEndIrq = (status_ff[ris_pkg::BIT_TX] && !txPhase) ||
                        (status_ff[ris_pkg::BIT_RX] && !rxPhase);

   // Cleared with the status; otherwise it would still hold the
   // pre-clear status and pulse the line for one cycle after it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ff <= 1'b0;
      end else if (statusClr || softClr) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= phaseEndIrq || |(status_ff[5:0] & mask_ff);
      end
   end
   // Clear drops the line at once, not a cycle late
   assign irqOut = irq_ff && !statusClr && !softClr;

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   // Valid the cycle after the strobe and held until the next
   // read, so the host may sample it late without harm
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            ris_pkg::ADDR_IRQ_STATUS: regRdata <= status_ff;
            ris_pkg::ADDR_COL_MASK:   regRdata <= {colPos_ff[9:8], mask_ff};
            ris_pkg::ADDR_COL_LOW:    regRdata <= colPos_ff[7:0];
            default:                  regRdata <= 8'h00;
         endcase
      end
   end

endmodule

// ===== ris_irq_status_sva.sv
/*
 Port checker for the interrupt status block.
 Assumes enablePin stays high around event traffic.
*/
`timescale 1ns/10ps
module ris_irq_status_sva (
   // Clock and reset
   input wire logic              mclk,
   input wire logic              rst_n,
   input wire logic              enablePin,
   // Register port
   input wire logic [4:0]        regAddr,
   input wire logic [7:0]        regWdata,
   input wire logic              regWr,
   input wire logic              regRd,
   // Events and outputs
   input wire ris_pkg::ris_evt_t evt,
   input wire logic              decoderEn,
   input wire logic              irqOut
);
   logic [5:0] mask_ff;
   // Mask shadow, so the masking checks need no probe
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask_ff <= 6'h3e;
      end else if (!enablePin) begin
         mask_ff <= 6'h3e;
      end else if (regWr && regAddr == 5'h0d) begin
         mask_ff <= regWdata[5:0];
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   a_read_drops_irq: assert property (
      regRd && regAddr == 5'h0c |-> !irqOut) else $error("irq up at status read");
   a_ctrl_wr_drop: assert property (
      regWr && regAddr == 5'h01 |-> !irqOut) else $error("irq up at ctrl write");
   a_tx_decoder_off: assert property (
      evt.txStart |=> !decoderEn) else $error("decoder on in tx");
   a_tx_irq_end: assert property (
      evt.txDone && !decoderEn |-> ##[1:3] irqOut) else $error("no irq after tx");
   a_rx_irq_late: assert property (
      evt.rxSof && !irqOut |=> !irqOut[*2]) else $error("irq early in rx");
   a_rx_irq_end: assert property (
      evt.rxSof ##[1:20] evt.rxDone |-> ##[1:3] irqOut) else $error("no irq after rx");
   a_masked_quiet: assert property (
      evt.noResp && !mask_ff[0] && !irqOut |=> !irqOut) else $error("masked irq");
   a_noresp_irq: assert property (
      evt.noResp && mask_ff[0] && decoderEn |-> ##[1:2] irqOut) else $error("no irq");
   c_tx_end: cover property (evt.txDone && !decoderEn);
   c_col_irq: cover property (evt.colEvent ##3 irqOut);
   c_masked: cover property (evt.noResp && !mask_ff[0]);
endmodule
bind ris_irq_status ris_irq_status_sva chk (.mclk(mclk), .rst_n(rst_n),
   .enablePin(enablePin), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
   .regRd(regRd), .evt(evt), .decoderEn(decoderEn), .irqOut(irqOut));

// ===== ris_host_model.sv
/*
 Host model driving the register port.
 Assumes a free-running mclk.
*/
`timescale 1ns/10ps
module ris_host_model (
   // Clock and read data
   input  wire logic       mclk,
   input  wire logic [7:0] regRdata,
   // Register port drive
   output logic      [4:0] regAddr,
   output logic      [7:0] regWdata,
   output logic            regWr,
   output logic            regRd,
   output logic            readEnd
);
   initial begin
      regAddr = 5'h00;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      readEnd = 1'b0;
   end
   // Strobes rise 1 ns after an edge, drop after the taking edge
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      @(posedge mclk);
      #1 regAddr = a;
      regWdata = v;
      regWr = 1'b1;
      @(posedge mclk);
      #1 regWr = 1'b0;
      regWdata = ~v; // Stale data inverted so it is never reused
   endtask
   // Status read is the acknowledge
   task automatic rd(input logic [4:0] a, output logic [7:0] v);
      @(posedge mclk);
      #1 regAddr = a;
      regRd = 1'b1;
      @(posedge mclk);
      #1 regRd = 1'b0;
      v = regRdata;
   endtask
   task automatic endRead();
      @(posedge mclk);
      #1 readEnd = 1'b1;
      @(posedge mclk);
      #1 readEnd = 1'b0;
   endtask
endmodule

// ===== ris_irq_status_bench.sv
/*
 Testbench: register reads against expected values.
 Assumes the host model drives the register port.
*/
`timescale 1ns/10ps
module ris_irq_status_bench;
   logic              mclk, rst_n, enablePin, typeAMode, colThreshSel;
   logic              regWr, regRd, readEnd, decoderEn, irqOut;
   logic        [4:0] regAddr, fifoCount;
   logic        [7:0] regWdata, regRdata, d;
   logic        [2:0] colCount;
   ris_pkg::ris_evt_t evt;
   int                error_cnt, comparisons;
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   ris_irq_status dut (.mclk(mclk), .rst_n(rst_n), .enablePin(enablePin),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .readEnd(readEnd), .regRdata(regRdata), .evt(evt), .fifoCount(fifoCount),
      .typeAMode(typeAMode), .colThreshSel(colThreshSel), .colCount(colCount),
      .decoderEn(decoderEn), .irqOut(irqOut));
   ris_host_model host (.mclk(mclk), .regRdata(regRdata), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .readEnd(readEnd));
   task automatic end_sim();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdChk(input logic [4:0] a, input logic [7:0] exp);
      host.rd(a, d);
      chk(d, exp);
   endtask
   // One-cycle event, then three edges so the line settles
   task automatic pulse(input logic [8:0] f, input logic [9:0] pos);
      @(posedge mclk);
      #1 evt = {f, pos};
      @(posedge mclk);
      #1 evt = '0;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   initial begin
      #20000;
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
   end
   initial begin
      {rst_n, typeAMode, colThreshSel, enablePin} = 4'b0101;
      {colCount, fifoCount, evt} = '0;
      colCount = 3'h6;
      fifoCount = 5'h05;
      repeat (8) @(posedge mclk);
      #1 rst_n = 1'b1;
      // Enable sync keeps state cleared for two more edges
      repeat (2) @(posedge mclk);
      rdChk(5'h0c, 8'h00);
      rdChk(5'h0d, 8'h3e);
      rdChk(5'h0e, 8'h00);
      // Transmit with a low FIFO; a CRC error in tx must be dropped
      fifoCount = 5'h03;
      pulse(9'h100, 10'h000);
      chk({7'h0, decoderEn}, 8'h00);
      pulse(9'h010, 10'h000);
      pulse(9'h080, 10'h000);
      fifoCount = 5'h05;
      chk({7'h0, irqOut}, 8'h01);
      chk({7'h0, decoderEn}, 8'h01);
      rdChk(5'h0c, 8'ha0);
      chk({7'h0, irqOut}, 8'h00);
      // Receive; parity error inside rx is ignored, irq waits for the end
      pulse(9'h040, 10'h000);
      pulse(9'h008, 10'h000);
      chk({7'h0, irqOut}, 8'h00);
      pulse(9'h020, 10'h000);
      chk({7'h0, irqOut}, 8'h01);
      rdChk(5'h0c, 8'h40);
      // Each error bit in turn; no-response is masked by default
      for (int i = 0; i < 5; i++) begin
         pulse(9'(1 << i), 10'h000);
         chk({7'h0, irqOut}, {7'h0, i != 0});
         rdChk(5'h0c, 8'(1 << i));
      end
      pulse(9'h004, 10'h000);
      host.wr(5'h01, 8'h80);
      @(posedge mclk);
      #1 chk({7'h0, irqOut}, 8'h00);
      pulse(9'h010, 10'h000);
      rdChk(5'h0c, 8'h00);
      pulse(9'h004, 10'h000);
      host.endRead();
      rdChk(5'h0c, 8'h00);
      // A count of six hits falls short of threshold seven, then reaches six
      colThreshSel = 1'b1;
      pulse(9'h002, 10'h2a5);
      rdChk(5'h0c, 8'h00);
      colThreshSel = 1'b0;
      pulse(9'h002, 10'h2a5);
      rdChk(5'h0c, 8'h02);
      rdChk(5'h0d, 8'hbe);
      rdChk(5'h0e, 8'ha5);
      rdChk(5'h0d, 8'h3e);
      rdChk(5'h0e, 8'h00);
      typeAMode = 1'b0;
      pulse(9'h004, 10'h155);
      rdChk(5'h0d, 8'h7e);
      rdChk(5'h0e, 8'h55);
      typeAMode = 1'b1;
      // Only no-response enabled
      host.wr(5'h0d, 8'h01);
      rdChk(5'h0c, 8'h04);
      pulse(9'h004, 10'h000);
      chk({7'h0, irqOut}, 8'h00);
      rdChk(5'h0c, 8'h04);
      pulse(9'h001, 10'h000);
      chk({7'h0, irqOut}, 8'h01);
      rdChk(5'h0d, 8'h01);
      // Enable low clears status and mask and drops the line
      enablePin = 1'b0;
      repeat (4) @(posedge mclk);
      #1 chk({7'h0, irqOut}, 8'h00);
      enablePin = 1'b1;
      repeat (3) @(posedge mclk);
      #1 chk({7'h0, irqOut}, 8'h00);
      rdChk(5'h0c, 8'h00);
      rdChk(5'h0d, 8'h3e);
      end_sim();
   end
endmodule
